/* File: sss_map.svh */
// Register map, field positions, reset values and word sizes of the
// synchronous serial slave port. Definitions only; included by bare name.
`ifndef SSS_MAP_SVH
`define SSS_MAP_SVH

// Register indices on the 3-bit register port
`define SSS_OFF_RX_STATUS   3'h0
`define SSS_OFF_TX_HOLD     3'h1
`define SSS_OFF_TX_STATUS   3'h2
`define SSS_OFF_BAUD_POL    3'h3
`define SSS_OFF_DIV_HIGH    3'h4
`define SSS_OFF_DIV_LOW     3'h5
`define SSS_OFF_RX_BUF      3'h6
`define SSS_OFF_WAKE_EN     3'h7

// receive_status_control bits
`define SSS_RS_PORT_EN      7
`define SSS_RS_RX9          6
`define SSS_RS_SINGLE_RECEIVE_ENABLE         5
`define SSS_RS_CONTINUOUS_RECEIVE_ENABLE         4
`define SSS_RS_ADDEN        3
`define SSS_RS_OVERRUN_ERROR_FLAG         1
`define SSS_RS_RX9D         0

// transmit_status_control bits
`define SSS_TS_CLOCK_SOURCE_SELECT         7
`define SSS_TS_TX9          6
`define SSS_TS_TRANSMIT_ENABLE         5
`define SSS_TS_SYNC         4
`define SSS_TS_SENDB        3
`define SSS_TS_BRGH         2
`define SSS_TS_SHIFT_REGISTER_EMPTY_STATUS         1
`define SSS_TS_TRANSMIT_NINTH_BIT         0

// baud_and_polarity_control bits
`define SSS_BP_DATA_POLARITY_INVERT        5
`define SSS_BP_CLOCK_POLARITY_INVERT        4

// wake enable bits
`define SSS_WE_TX           0
`define SSS_WE_RX           1

// Reset values and word sizes
`define SSS_RST_BYTE        8'h00
`define SSS_LAST_BIT8       4'h7
`define SSS_LAST_BIT9       4'h8

`endif

/* File: sss_pkg.sv */
// Types of the synchronous serial slave port.
// Assumes sss_map.svh supplies the numeric constants.
package sss_pkg;

	// Whole state of the port, registered as one word
	typedef struct packed {
		logic       ck_s1;
		logic       ck_s2;
		logic       ck_s3;
		logic       dt_s1;
		logic       dt_s2;
		logic       port_en;
		logic       rx9;
		logic       single_receive_enable;
		logic       continuous_receive_enable;
		logic       adden;
		logic       clock_source_select;
		logic       tx9;
		logic       transmit_enable;
		logic       sync;
		logic       sendb;
		logic       brgh;
		logic       transmit_ninth_bit;
		logic [7:0] baud_pol;
		logic [7:0] div_high;
		logic [7:0] div_low;
		logic [1:0] wake_en;
		logic [7:0] hold;
		logic       hold9;
		logic       txif;
		logic [8:0] transmit_shift_register;
		logic       tsr_busy;
		logic       shift_register_empty_status;
		logic [3:0] tx_cnt;
		logic [8:0] receive_shift_register;
		logic [3:0] rx_cnt;
		logic [7:0] rcreg;
		logic       rx9d;
		logic       rcif;
		logic       overrun_error_flag;
		logic [7:0] rdata;
		logic       wake;
		logic       dt_out;
		logic       dt_oe_b;
	} sss_state_t;

endpackage

/* File: sss_slave_port.sv */
// Synchronous slave serial port: holding/shift registers for both
// directions, clock and data taken from an external master.
// Assumes a register master on core_clk_in and pins from outside,
// synchronised here before use.
//
// Contract
// - Slave operation when port, sync mode on and clock source select clear.
// - Shift clock comes only from the external master, never driven here.
// - Words keep shifting during low-power modes, clocked from the pin.
// - First written word moves to shifter at once; second waits in holding.
// - Buffer-free flag stays clear while a word waits in holding.
// - After shift-out, held word moves to shifter and buffer-free flag sets in the same cycle.
// - Buffer-free flag with the transmit wake enable bit raises the wake request.
// - Clock and data pin signals are inverted by their polarity bits.
// - With transmit enabled, writing the holding register starts sending.
// - Single-receive enable is ignored; only continuous receive matters.
// - Continuous receive works during low-power modes.
// - A complete word moves from receive shifter into receive buffer.
// - Completed reception with the receive wake enable bit raises the wake request.
// - Receive-ready flag sets when a reception completes.
// - Receive buffer presents the eight received data bits.
// - Clearing continuous receive clears a pending receive error.
// - Receive data is sampled on the falling shift clock edge.
// - Reception continues word after word until continuous receive clears or an overrun sets.
`timescale 1ns/1ps
`default_nettype none
`include "sss_map.svh"

module sss_slave_port
(
	input  wire logic       core_clk_in,
	input  wire logic       rst_b_in,
	input  wire logic [2:0] reg_addr_in,
	input  wire logic [7:0] reg_wdata_in,
	input  wire logic       reg_wr_in,
	input  wire logic       reg_rd_in,
	output var  logic [7:0] reg_rdata_out,
	input  wire logic       serial_clock_pin_in,
	input  wire logic       serial_data_pin_in,
	output var  logic       serial_data_pin_out,
	output var  logic       serial_data_pin_oe_b_out,
	output var  logic       tx_buffer_free_out,
	output var  logic       rx_ready_out,
	output var  logic       shift_empty_out,
	output var  logic       wake_out
);

	////////////////////////////////////////////////////////////////////////
	// State

	sss_pkg::sss_state_t s_q;
	sss_pkg::sss_state_t s_d;

	logic       slave_on;
	logic       ck_now;
	logic       ck_prev;
	logic       fall;
	logic       din;
	logic       rx_on;
	logic [3:0] tx_last;
	logic [3:0] rx_last;
	logic       rx_done;
	logic       rd_buf;
	logic       wr_txh;
	logic       continuous_receive_enable_off;

	////////////////////////////////////////////////////////////////////////
	// Decoded conditions

	// Slave mode only; master and asynchronous modes are not built here
	assign slave_on = s_q.port_en & s_q.sync & ~s_q.clock_source_select;
	// Clock is only sampled, this port has no clock output at all
	assign ck_now   = s_q.ck_s2 ^ s_q.baud_pol[`SSS_BP_CLOCK_POLARITY_INVERT];
	assign ck_prev  = s_q.ck_s3 ^ s_q.baud_pol[`SSS_BP_CLOCK_POLARITY_INVERT];
	// Edges come from the pin, so shifting needs no internal baud timer
	assign fall     = ck_prev & ~ck_now & slave_on;
	assign din      = s_q.dt_s2 ^ s_q.baud_pol[`SSS_BP_DATA_POLARITY_INVERT];
	// Pin is shared, so receive stands aside while transmit owns it
	assign rx_on    = slave_on & s_q.continuous_receive_enable & ~s_q.transmit_enable & ~s_q.overrun_error_flag;
	assign tx_last  = s_q.tx9 ? `SSS_LAST_BIT9 : `SSS_LAST_BIT8;
	assign rx_last  = s_q.rx9 ? `SSS_LAST_BIT9 : `SSS_LAST_BIT8;
	assign rx_done  = rx_on & fall & (s_q.rx_cnt == rx_last);
	assign rd_buf   = reg_rd_in & (reg_addr_in == `SSS_OFF_RX_BUF);
	assign wr_txh   = reg_wr_in & (reg_addr_in == `SSS_OFF_TX_HOLD);
	assign continuous_receive_enable_off = reg_wr_in & (reg_addr_in == `SSS_OFF_RX_STATUS)
		& ~reg_wdata_in[`SSS_RS_CONTINUOUS_RECEIVE_ENABLE];

	////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb
	begin
		s_d = s_q;

		// Two flip-flops on every pin before any logic reads it
		s_d.ck_s1 = serial_clock_pin_in;
		s_d.ck_s2 = s_q.ck_s1;
		s_d.ck_s3 = s_q.ck_s2;
		s_d.dt_s1 = serial_data_pin_in;
		s_d.dt_s2 = s_q.dt_s1;

		// Register writes
		if (reg_wr_in)
		begin
			unique case (reg_addr_in)
				`SSS_OFF_RX_STATUS:
				begin
					s_d.port_en = reg_wdata_in[`SSS_RS_PORT_EN];
					s_d.rx9     = reg_wdata_in[`SSS_RS_RX9];
					s_d.single_receive_enable    = reg_wdata_in[`SSS_RS_SINGLE_RECEIVE_ENABLE];
					s_d.continuous_receive_enable    = reg_wdata_in[`SSS_RS_CONTINUOUS_RECEIVE_ENABLE];
					s_d.adden   = reg_wdata_in[`SSS_RS_ADDEN];
				end
				`SSS_OFF_TX_HOLD:
				begin
					// Overwrites a waiting word; software checks the flag first
					s_d.hold  = reg_wdata_in;
					s_d.hold9 = s_q.transmit_ninth_bit;
				end
				`SSS_OFF_TX_STATUS:
				begin
					s_d.clock_source_select  = reg_wdata_in[`SSS_TS_CLOCK_SOURCE_SELECT];
					s_d.tx9   = reg_wdata_in[`SSS_TS_TX9];
					s_d.transmit_enable  = reg_wdata_in[`SSS_TS_TRANSMIT_ENABLE];
					s_d.sync  = reg_wdata_in[`SSS_TS_SYNC];
					s_d.sendb = reg_wdata_in[`SSS_TS_SENDB];
					s_d.brgh  = reg_wdata_in[`SSS_TS_BRGH];
					s_d.transmit_ninth_bit  = reg_wdata_in[`SSS_TS_TRANSMIT_NINTH_BIT];
				end
				`SSS_OFF_BAUD_POL: s_d.baud_pol = reg_wdata_in;
				`SSS_OFF_DIV_HIGH: s_d.div_high = reg_wdata_in;
				`SSS_OFF_DIV_LOW:  s_d.div_low  = reg_wdata_in;
				`SSS_OFF_WAKE_EN:  s_d.wake_en  = reg_wdata_in[1:0];
				default:           s_d.wake_en  = s_q.wake_en;
			endcase
		end

		// A written word occupies the holding register until moved
		if (wr_txh)
			s_d.txif = 1'b0;

		// Transmit shifter: one bit per falling edge, LSB first
		if (s_q.tsr_busy && fall)
		begin
			if (s_q.tx_cnt == tx_last)
				s_d.tsr_busy = 1'b0;
			else
				s_d.tx_cnt = s_q.tx_cnt + 4'h1;
		end

		// Held word moves as soon as the shifter is free
		if (slave_on && s_q.transmit_enable && !s_q.txif && !s_q.tsr_busy && !wr_txh)
		begin
			s_d.transmit_shift_register      = {s_q.hold9, s_q.hold};
			s_d.tsr_busy = 1'b1;
			s_d.tx_cnt   = 4'h0;
			s_d.txif     = 1'b1;
		end

		// Disabling transmit or the port abandons the word in flight
		if (!slave_on || !s_q.transmit_enable)
			s_d.tsr_busy = 1'b0;

		// Empty only with nothing in the shifter
		s_d.shift_register_empty_status = ~s_d.tsr_busy;

		// Receive shifter: bit lands at its own position
		if (rx_on && fall)
		begin
			s_d.receive_shift_register[s_q.rx_cnt] = din;
			s_d.rx_cnt = (s_q.rx_cnt == rx_last) ? 4'h0 : s_q.rx_cnt + 4'h1;
		end
		if (!rx_on)
			s_d.rx_cnt = 4'h0;

		// Reading the buffer frees it; a completion in the same cycle refills it
		if (rd_buf)
			s_d.rcif = 1'b0;

		// Completion over an unread buffer is an overrun; the word is dropped
		if (rx_done)
		begin
			if (s_q.rcif && !rd_buf)
				s_d.overrun_error_flag = 1'b1;
			else
			begin
				s_d.rcreg = s_q.rx9 ? s_d.receive_shift_register[7:0] : s_d.receive_shift_register[7:0];
				s_d.rx9d  = s_q.rx9 & s_d.receive_shift_register[8];
				s_d.rcif  = 1'b1;
			end
		end

		// Turning continuous receive off is the only way out of overrun
		if (continuous_receive_enable_off)
			s_d.overrun_error_flag = 1'b0;

		// Wake request follows the flags and their enables
		s_d.wake = (s_d.txif & s_q.wake_en[`SSS_WE_TX])
			| (s_d.rcif & s_q.wake_en[`SSS_WE_RX]);

		// Data pin: driven only while transmit owns it, idle level high before the data polarity bit
		s_d.dt_oe_b = ~(slave_on & s_q.transmit_enable);
		s_d.dt_out  = (s_d.tsr_busy ? s_d.transmit_shift_register[s_d.tx_cnt] : 1'b1)
			^ s_q.baud_pol[`SSS_BP_DATA_POLARITY_INVERT];

		// Read data stands only in the cycle after the strobe
		s_d.rdata = `SSS_RST_BYTE;
		if (reg_rd_in)
		begin
			unique case (reg_addr_in)
				`SSS_OFF_RX_STATUS: s_d.rdata = {s_q.port_en, s_q.rx9, s_q.single_receive_enable,
					s_q.continuous_receive_enable, s_q.adden, 1'b0, s_q.overrun_error_flag, s_q.rx9d};
				`SSS_OFF_TX_HOLD:   s_d.rdata = `SSS_RST_BYTE;
				`SSS_OFF_TX_STATUS: s_d.rdata = {s_q.clock_source_select, s_q.tx9, s_q.transmit_enable,
					s_q.sync, s_q.sendb, s_q.brgh, s_q.shift_register_empty_status, s_q.transmit_ninth_bit};
				`SSS_OFF_BAUD_POL:  s_d.rdata = s_q.baud_pol;
				`SSS_OFF_DIV_HIGH:  s_d.rdata = s_q.div_high;
				`SSS_OFF_DIV_LOW:   s_d.rdata = s_q.div_low;
				`SSS_OFF_RX_BUF:    s_d.rdata = s_q.rcreg;
				`SSS_OFF_WAKE_EN:   s_d.rdata = {6'h00, s_q.wake_en};
				default:            s_d.rdata = `SSS_RST_BYTE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registers

	// Reset leaves the port off, flags showing free and empty
	always_ff @(posedge core_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			s_q         <= '0;
			s_q.ck_s1   <= 1'b0;
			s_q.txif    <= 1'b1;
			s_q.shift_register_empty_status    <= 1'b1;
			s_q.dt_out  <= 1'b1;
			s_q.dt_oe_b <= 1'b1;
			s_q.wake    <= 1'b0;
		end
		else
			s_q <= s_d;
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs, each straight from a flip-flop

	assign reg_rdata_out            = s_q.rdata;
	assign serial_data_pin_out      = s_q.dt_out;
	assign serial_data_pin_oe_b_out = s_q.dt_oe_b;
	assign tx_buffer_free_out       = s_q.txif;
	assign rx_ready_out             = s_q.rcif;
	assign shift_empty_out          = s_q.shift_register_empty_status;
	assign wake_out                 = s_q.wake;

endmodule

`default_nettype wire

/* File: sss_port_chk_props.sv */
// Checker of the serial slave port, watching the top module's ports only.
// Assumes the flag and read timing handed over with the design.
`timescale 1ns/1ps
`default_nettype none
`include "sss_map.svh"
module sss_port_chk
(
	input wire logic       core_clk_in,
	input wire logic       rst_b_in,
	input wire logic [2:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic       reg_wr_in,
	input wire logic       reg_rd_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic       serial_clock_pin_in,
	input wire logic       serial_data_pin_in,
	input wire logic       serial_data_pin_out,
	input wire logic       serial_data_pin_oe_b_out,
	input wire logic       tx_buffer_free_out,
	input wire logic       rx_ready_out,
	input wire logic       shift_empty_out,
	input wire logic       wake_out
);
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!rst_b_in);
	////////////////////////////////////////
	// Register port steps
	sequence hold_wr;
		reg_wr_in && reg_addr_in == `SSS_OFF_TX_HOLD;
	endsequence
	sequence buf_rd;
		reg_rd_in && reg_addr_in == `SSS_OFF_RX_BUF;
	endsequence
	chk_rd_idle_zero: assert property (
		!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
		else $error("read data outside its cycle");
	chk_hold_clears_free: assert property (
		hold_wr |=> !tx_buffer_free_out)
		else $error("buffer free after holding write");
	// Oe low stands in for an active transmitter
	chk_first_word_loads: assert property (
		hold_wr ##0 (shift_empty_out && !serial_data_pin_oe_b_out) |-> ##[1:3] !shift_empty_out)
		else $error("first word not loaded");
	chk_load_frees_buf: assert property (
		$fell(shift_empty_out) |-> tx_buffer_free_out)
		else $error("shifter loaded without freeing buffer");
	chk_read_clears_rdy: assert property (
		buf_rd ##0 rx_ready_out |=> !rx_ready_out)
		else $error("ready kept after buffer read");
	chk_ready_holds: assert property (
		rx_ready_out && !reg_rd_in |=> rx_ready_out)
		else $error("ready dropped without read");
	chk_wake_has_cause: assert property (
		wake_out |-> tx_buffer_free_out || rx_ready_out || $past(tx_buffer_free_out) || $past(rx_ready_out))
		else $error("wake without flag");
	chk_rx_not_driving: assert property (
		$rose(rx_ready_out) |-> serial_data_pin_oe_b_out)
		else $error("word received while driving");
endmodule
bind sss_slave_port sss_port_chk i_chk (.*);
`default_nettype wire

/* File: sss_ext_master.sv */
// Behavioural external master: makes the shift clock and moves words.
// Assumes the bench resolves the shared data wire and feeds it back.
`timescale 1ns/1ps
`default_nettype none
module sss_ext_master
(
	output logic      ck_out,
	output logic      dt_out,
	input  wire logic dt_in
);
	initial
	begin
		ck_out = 1'b1;
		dt_out = 1'b1;
	end
	// One frame LSB first; clock stands still between frames, wire is left toggled
	task automatic frame(input logic [8:0] w, input int n, input logic snd, input logic inv, output logic [8:0] got);
		got = 9'h000;
		ck_out = ~inv;
		#43;
		for (int i = 0; i < n; i++)
		begin
			dt_out = snd ? w[i] ^ inv : ~dt_out;
			#38;
			got[i] = dt_in ^ inv;
			#2 ck_out = inv;
			#40 ck_out = ~inv;
		end
		#40 dt_out = ~dt_out;
	endtask
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Bench of the serial slave port: register tasks, transmit and receive frames.
// Assumes the master model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`include "sss_map.svh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb_top;
	logic       core_clk_in = 1'b0;
	logic       rst_b_in = 1'b0;
	logic [2:0] reg_addr_in = 3'h0;
	logic [7:0] reg_wdata_in = 8'h00;
	logic       reg_wr_in = 1'b0;
	logic       reg_rd_in = 1'b0;
	logic [7:0] reg_rdata_out;
	logic       serial_clock_pin_in;
	logic       serial_data_pin_out;
	logic       serial_data_pin_oe_b_out;
	logic       tx_buffer_free_out;
	logic       rx_ready_out;
	logic       shift_empty_out;
	logic       wake_out;
	logic       m_dt;
	logic [8:0] got;
	int         bad_count = 0;
	int         tests_run = 0;
	int         cyc = 0;
	wire logic  serial_data_pin_in = serial_data_pin_oe_b_out ? m_dt : serial_data_pin_out;
	sss_slave_port i_dut (.*);
	sss_ext_master i_mst (.ck_out(serial_clock_pin_in), .dt_out(m_dt), .dt_in(serial_data_pin_in));
	always #5 core_clk_in = ~core_clk_in;
	////////////////////////////////////////
	// Cycle limit cuts a hang short
	always @(posedge core_clk_in)
	begin
		cyc++;
		if (cyc == 6000)
		begin
			bad_count++;
			test_done();
		end
	end
	task automatic test_done();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge core_clk_in);
		reg_wr_in <= 1'b1;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		@(posedge core_clk_in);
		reg_wr_in <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [2:0] a, input logic [7:0] e, input string nm);
		@(posedge core_clk_in);
		reg_rd_in <= 1'b1;
		reg_addr_in <= a;
		@(posedge core_clk_in);
		reg_rd_in <= 1'b0;
		#1 `CHK(nm, e, reg_rdata_out)
	endtask
	// Frames start on the clock edge; pin changes inside fall between edges, but the idle clock level is set on the edge and can race the sampler
	task automatic fr(input logic [8:0] w, input int n, input logic snd, input logic inv);
		@(posedge core_clk_in);
		i_mst.frame(w, n, snd, inv, got);
	endtask
	////////////////////////////////////////
	task automatic t_reset();
		`CHK("flags", 4'hA, {tx_buffer_free_out, rx_ready_out, shift_empty_out, wake_out})
		rd(`SSS_OFF_TX_STATUS, 8'h02, "txstat");
		wr(`SSS_OFF_RX_BUF, 8'hFF);
		rd(`SSS_OFF_RX_BUF, 8'h00, "robuf");
	endtask
	task automatic t_tx_pair();
		wr(`SSS_OFF_RX_STATUS, 8'h80);
		wr(`SSS_OFF_TX_STATUS, 8'h30);
		wr(`SSS_OFF_WAKE_EN, 8'h01);
		wr(`SSS_OFF_TX_HOLD, 8'hA5);
		wr(`SSS_OFF_TX_HOLD, 8'h3C);
		repeat (3) @(posedge core_clk_in);
		#1 `CHK("wait", 2'b00, {tx_buffer_free_out, wake_out})
		fr(9'h000, 8, 1'b0, 1'b0);
		`CHK("word1", 9'h0A5, got)
		`CHK("reload", 3'b101, {tx_buffer_free_out, shift_empty_out, wake_out})
		fr(9'h000, 8, 1'b0, 1'b0);
		`CHK("word2", 9'h03C, got)
		`CHK("empty", 1'b1, shift_empty_out)
	endtask
	task automatic t_tx_nine();
		wr(`SSS_OFF_TX_STATUS, 8'h10);
		wr(`SSS_OFF_BAUD_POL, 8'h30);
		fr(9'h000, 0, 1'b0, 1'b1);
		wr(`SSS_OFF_TX_STATUS, 8'h71);
		wr(`SSS_OFF_TX_HOLD, 8'h5A);
		fr(9'h000, 9, 1'b0, 1'b1);
		`CHK("nine", 9'h15A, got)
		wr(`SSS_OFF_TX_STATUS, 8'h10);
		wr(`SSS_OFF_BAUD_POL, 8'h00);
		fr(9'h000, 0, 1'b0, 1'b0);
	endtask
	task automatic t_rx();
		wr(`SSS_OFF_WAKE_EN, 8'h02);
		wr(`SSS_OFF_RX_STATUS, 8'hB0);
		#1 `CHK("nowake", 1'b0, wake_out)
		fr(9'h06B, 8, 1'b1, 1'b0);
		`CHK("rxflag", 2'b11, {rx_ready_out, wake_out})
		rd(`SSS_OFF_RX_STATUS, 8'hB0, "rxstat");
		rd(`SSS_OFF_RX_BUF, 8'h6B, "rxbuf");
		`CHK("rxclr", 1'b0, rx_ready_out)
		fr(9'h011, 8, 1'b1, 1'b0);
		fr(9'h022, 8, 1'b1, 1'b0);
		rd(`SSS_OFF_RX_STATUS, 8'hB2, "ovr");
		rd(`SSS_OFF_RX_BUF, 8'h11, "keep");
		wr(`SSS_OFF_RX_STATUS, 8'h80);
		rd(`SSS_OFF_RX_STATUS, 8'h80, "ovclr");
		wr(`SSS_OFF_RX_STATUS, 8'hD0);
		fr(9'h1C3, 9, 1'b1, 1'b0);
		rd(`SSS_OFF_RX_STATUS, 8'hD1, "rx9");
		rd(`SSS_OFF_RX_BUF, 8'hC3, "rx9buf");
	endtask
	initial
	begin
		repeat (6) @(posedge core_clk_in);
		rst_b_in <= 1'b1;
		@(posedge core_clk_in);
		#1 t_reset();
		t_tx_pair();
		t_tx_nine();
		t_rx();
		test_done();
	end
endmodule
`default_nettype wire
